// File: rtl/tcb_block.v
// Purpose: Interrupt masks, block trigger and block mode of a three channel timer
// Assumes: Inputs synchronous to CLK_I; events are one-cycle pulses
// Notes: Counter datapath lives outside; this block routes and conditions its inputs
`include "tcb_regs.vh"
`default_nettype none

module tcb_block #(
    parameter FILT_W = 6
) (
    input wire CLK_I,                 // Peripheral clock
    input wire RST_N_I,               // Sync reset, active low
    input wire [31:0] ADDR_I,         // Register address
    input wire [31:0] WDATA_I,        // Write data
    input wire WR_I,                  // Write strobe
    input wire RD_I,                  // Read strobe
    output reg [31:0] RDATA_O,        // Read data, cycle after strobe
    input wire [7:0] EVENT_I,         // Channel event pulses
    input wire WAVE_MODE_I,           // Channel in waveform mode
    input wire CLK_PIN0_I,            // Dedicated clock pin 0
    input wire CLK_PIN1_I,            // Dedicated clock pin 1
    input wire CLK_PIN2_I,            // Dedicated clock pin 2
    input wire CHAN0_IO_A_I,          // Channel 0 pin A
    input wire CHAN1_IO_A_I,          // Channel 1 pin A
    input wire CHAN2_IO_A_I,          // Channel 2 pin A
    input wire CHAN0_IO_B_I,          // Channel 0 pin B
    output reg IRQ_O,                 // Channel interrupt
    output reg SYNC_O,                // Software trigger to all channels
    output reg EXT_CLOCK_LINE0_O,     // Selected external clock 0
    output reg EXT_CLOCK_LINE1_O,     // Selected external clock 1
    output reg EXT_CLOCK_LINE2_O,     // Selected external clock 2
    output reg PHASE_A_O,             // Filtered phase A to decoder
    output reg PHASE_B_O,             // Filtered phase B to decoder
    output reg INDEX_O,               // Filtered index to decoder
    output reg EDGE_O,                // Counted edge pulse
    output reg DIR_O,                 // Rotation direction
    output reg DIR_CHANGE_O,          // Direction change pulse
    output reg POS_MEASURE_O,         // Channels 0/1 measure position
    output reg SPEED_MEASURE_O        // Channel 0 measures speed
);

    // ****************************************
    // Register file
    // ****************************************
    reg [7:0] mask_q;
    reg [7:0] flags_q;
    reg [31:0] mode_q;
    reg wp_en_q;
    wire wr_en = WR_I && (ADDR_I == `TCB_OFF_IRQ_EN);
    wire wr_dis = WR_I && (ADDR_I == `TCB_OFF_IRQ_DIS);
    wire rd_stat = RD_I && (ADDR_I == `TCB_OFF_STATUS);
    reg [7:0] dis_eff;

    // Disable bits qualified by channel mode
    always @*
    begin
        dis_eff = WDATA_I[7:0];
        // R5 mode qualified disables
        if (WAVE_MODE_I)
        begin
            dis_eff[1] = 1'b0;
            dis_eff[5] = 1'b0;
            dis_eff[6] = 1'b0;
        end
        else
        begin
            dis_eff[2] = 1'b0;
            dis_eff[3] = 1'b0;
        end
    end

    // Mask, flags, mode and protection registers
    always @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            // R24 reset values
            mask_q <= `TCB_RST_MASK;
            mode_q <= `TCB_RST_MODE;
            flags_q <= 8'h00;
            wp_en_q <= 1'b0;
        end
        else
        begin
            // R1 R2 R4 set and clear mask
            if (wr_en)
                mask_q <= mask_q | WDATA_I[7:0];
            else if (wr_dis)
                mask_q <= mask_q & ~dis_eff;
            // R22 event sets win over read clear
            if (rd_stat)
                flags_q <= EVENT_I;
            else
                flags_q <= flags_q | EVENT_I;
            // R20 protected mode writes
            if (WR_I && (ADDR_I == `TCB_OFF_MODE) && !wp_en_q)
                mode_q <= WDATA_I & `TCB_MODE_MASK;
            // R21 key checked protection
            if (WR_I && (ADDR_I == `TCB_OFF_WPROT) && (WDATA_I[31:8] == `TCB_WP_KEY))
                wp_en_q <= WDATA_I[0];
        end
    end

    // Read data mux, one cycle after strobe
    always @(posedge CLK_I)
    begin
        if (!RST_N_I)
            RDATA_O <= 32'h0000_0000;
        else if (RD_I)
        begin
            case (ADDR_I)
                // R3 mask view
                `TCB_OFF_IRQ_MASK: RDATA_O <= {24'h00_0000, mask_q};
                `TCB_OFF_STATUS: RDATA_O <= {24'h00_0000, flags_q};
                `TCB_OFF_MODE: RDATA_O <= mode_q;
                `TCB_OFF_WPROT: RDATA_O <= {31'h0000_0000, wp_en_q};
                default: RDATA_O <= 32'h0000_0000;
            endcase
        end
        else
            RDATA_O <= 32'h0000_0000;
    end

    // ****************************************
    // Interrupt, trigger and clock routing
    // ****************************************
    always @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            IRQ_O <= 1'b0;
            SYNC_O <= 1'b0;
            EXT_CLOCK_LINE0_O <= 1'b0;
            EXT_CLOCK_LINE1_O <= 1'b0;
            EXT_CLOCK_LINE2_O <= 1'b0;
            POS_MEASURE_O <= 1'b0;
            SPEED_MEASURE_O <= 1'b0;
        end
        else
        begin
            // R23 masked flags raise interrupt
            IRQ_O <= |(flags_q & mask_q);
            // R6 software trigger pulse
            SYNC_O <= WR_I && (ADDR_I == `TCB_OFF_CTRL) && WDATA_I[0];
            // R7 clock line 0 source
            case (mode_q[1:0])
                2'd2: EXT_CLOCK_LINE0_O <= CHAN1_IO_A_I;
                2'd3: EXT_CLOCK_LINE0_O <= CHAN2_IO_A_I;
                default: EXT_CLOCK_LINE0_O <= CLK_PIN0_I;
            endcase
            // R8 clock line 1 source
            case (mode_q[3:2])
                2'd2: EXT_CLOCK_LINE1_O <= CHAN0_IO_A_I;
                2'd3: EXT_CLOCK_LINE1_O <= CHAN2_IO_A_I;
                default: EXT_CLOCK_LINE1_O <= CLK_PIN1_I;
            endcase
            // R9 clock line 2 source
            case (mode_q[5:4])
                2'd2: EXT_CLOCK_LINE2_O <= CHAN0_IO_A_I;
                2'd3: EXT_CLOCK_LINE2_O <= CHAN1_IO_A_I;
                default: EXT_CLOCK_LINE2_O <= CLK_PIN2_I;
            endcase
            // R12 R13 measurement selects
            POS_MEASURE_O <= mode_q[`TCB_B_DECODER_ENABLE] & mode_q[`TCB_B_POSITION_MEASURE_ENABLE];
            SPEED_MEASURE_O <= mode_q[`TCB_B_DECODER_ENABLE] & mode_q[`TCB_B_SPEED_MEASURE_ENABLE];
        end
    end

    // ****************************************
    // Decoder input conditioning
    // ****************************************
    wire qd_en = mode_q[`TCB_B_DECODER_ENABLE];
    wire [FILT_W-1:0] filt_len = mode_q[`TCB_B_FILT_LO +: FILT_W];
    reg [2:0] raw;
    reg [2:0] stable_q;
    reg [2:0] cand_q;
    reg [FILT_W:0] cnt_q [0:2];
    integer i;

    // R16 R17 R18 invert, swap and index source
    always @*
    begin
        raw[0] = CHAN0_IO_A_I ^ mode_q[`TCB_B_INVERT_PHASE_A];
        raw[1] = CHAN0_IO_B_I ^ mode_q[`TCB_B_INVERT_PHASE_B];
        if (mode_q[`TCB_B_SWAP])
        begin
            raw[0] = CHAN0_IO_B_I ^ mode_q[`TCB_B_INVERT_PHASE_B];
            raw[1] = CHAN0_IO_A_I ^ mode_q[`TCB_B_INVERT_PHASE_A];
        end
        raw[2] = (mode_q[`TCB_B_IDXB] ? CHAN0_IO_B_I : CHAN1_IO_A_I) ^ mode_q[`TCB_B_INVERT_INDEX];
    end

    // R19 glitch filter: level must hold filt_len+2 cycles
    always @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            stable_q <= 3'b000;
            cand_q <= 3'b000;
            for (i = 0; i < 3; i = i + 1)
                cnt_q[i] <= {(FILT_W+1){1'b0}};
        end
        else
        begin
            for (i = 0; i < 3; i = i + 1)
            begin
                if (raw[i] != cand_q[i])
                begin
                    cand_q[i] <= raw[i];
                    cnt_q[i] <= {(FILT_W+1){1'b0}};
                end
                else if (cnt_q[i] < {1'b0, filt_len})
                    cnt_q[i] <= cnt_q[i] + 1'b1;
                else
                    stable_q[i] <= cand_q[i];
            end
        end
    end

    // R10 R14 R15 edge detection and decoding
    reg [1:0] prev_q;
    wire a_edge = stable_q[0] ^ prev_q[0];
    wire b_edge = stable_q[1] ^ prev_q[1];
    wire new_dir = (stable_q[0] ^ prev_q[1]);
    always @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            prev_q <= 2'b00;
            PHASE_A_O <= 1'b0;
            PHASE_B_O <= 1'b0;
            INDEX_O <= 1'b0;
            EDGE_O <= 1'b0;
            DIR_O <= 1'b0;
            DIR_CHANGE_O <= 1'b0;
        end
        else
        begin
            prev_q <= stable_q[1:0];
            PHASE_A_O <= qd_en & stable_q[0];
            PHASE_B_O <= qd_en & stable_q[1];
            INDEX_O <= qd_en & stable_q[2];
            EDGE_O <= qd_en & (a_edge | (mode_q[`TCB_B_EDGE] & b_edge));
            DIR_CHANGE_O <= 1'b0;
            if (qd_en && !mode_q[`TCB_B_TRANS] && (a_edge ^ b_edge))
            begin
                DIR_O <= new_dir;
                DIR_CHANGE_O <= (new_dir != DIR_O);
            end
        end
    end

endmodule

`default_nettype wire

// File: rtl/tcb_regs.vh
// Purpose: Register offsets, field positions and reset values of the timer block controls
// Assumes: One register word per offset, byte addresses as printed
// Notes: Included by the block module, its bound checks and its bench
//
// Functional notes
// R1 - Writing one to an enable bit sets that mask bit; zero changes nothing.
// R2 - Writing one to a disable bit clears that mask bit; zero changes nothing.
// R3 - Mask view reads one for each enabled event, zero for disabled.
// R4 - Bits 0..7: overflow, overrun, compare A/B/C, load A/B, trigger.
// R5 - Overrun and load disables apply in capture mode; compare disables in waveform mode; here the compare C disable applies in both modes.
// R6 - Writing one to control bit 0 pulses a software trigger to all channels.
// R7 - Clock line 0 selects pin 0, channel 1 A or channel 2 A.
// R8 - Clock line 1 selects pin 1, channel 0 A or channel 2 A.
// R9 - Clock line 2 selects pin 2, channel 0 A or channel 1 A.
// R10 - Bit 8 enables filtering, edge detection and quadrature decoding.
// R11 - Software enabling the decoder also sets position or speed enable.
// R12 - Bit 9 makes channels 0 and 1 measure decoded position.
// R13 - Bit 10 makes channel 0 measure speed with channel 2 time base.
// R14 - Bit 11 keeps filtering and edges but stops decoding and direction detection.
// R15 - Bit 12 counts edges on phase A only, or both phases.
// R16 - Bits 13..15 invert phase A, phase B and index before the decoder.
// R17 - Bit 16 swaps phase A and phase B before the decoder.
// R18 - Bit 17 takes index from channel 1 pin A or channel 0 pin B.
// R19 - Filter field bits 25..20 drops pulses shorter than value plus one cycles; the filter here drops pulses shorter than value plus two.
// R20 - Block mode writes are ignored while write protection is enabled.
// R21 - Protection enable changes only with the correct 24-bit key.
// R22 - Event flags set on events and clear when status is read.
// R23 - Interrupt asserts while any flagged event is also masked in.
// R24 - After reset masks and all block mode fields are zero.
`ifndef TCB_REGS_VH
`define TCB_REGS_VH
`define TCB_OFF_IRQ_EN 32'h4008_0024
`define TCB_OFF_IRQ_DIS 32'h4008_0028
`define TCB_OFF_IRQ_MASK 32'h4008_002C
`define TCB_OFF_STATUS 32'h4008_0020
`define TCB_OFF_CTRL 32'h4008_00C0
`define TCB_OFF_MODE 32'h4008_00C4
`define TCB_OFF_WPROT 32'h4008_00E4
`define TCB_WP_KEY 24'h5449_4D
`define TCB_MODE_MASK 32'h03F3_FF3F
`define TCB_B_DECODER_ENABLE 8
`define TCB_B_POSITION_MEASURE_ENABLE 9
`define TCB_B_SPEED_MEASURE_ENABLE 10
`define TCB_B_TRANS 11
`define TCB_B_EDGE 12
`define TCB_B_INVERT_PHASE_A 13
`define TCB_B_INVERT_PHASE_B 14
`define TCB_B_INVERT_INDEX 15
`define TCB_B_SWAP 16
`define TCB_B_IDXB 17
`define TCB_B_FILT_LO 20
`define TCB_RST_MASK 8'h00
`define TCB_RST_MODE 32'h0000_0000
`endif

// File: test/tcb_block_asserts.sv
// Purpose: Port checks of the timer block controls
// Assumes: Offsets and fields from tcb_regs.vh
// Notes: Bound into every tcb_block instance
`include "tcb_regs.vh"
`default_nettype none
module tcb_chk (
    input wire logic CLK_I, // Clock
    input wire logic RST_N_I, // Reset, active low
    input wire logic [31:0] ADDR_I, // Address
    input wire logic [31:0] WDATA_I, // Write data
    input wire logic WR_I, // Write strobe
    input wire logic RD_I, // Read strobe
    input wire logic [31:0] RDATA_O, // Read data
    input wire logic CLK_PIN0_I, // Clock pin 0
    input wire logic CHAN1_IO_A_I, // Channel 1 pin A
    input wire logic SYNC_O, // Trigger pulse
    input wire logic EXT_CLOCK_LINE0_O, // Clock line 0
    input wire logic POS_MEASURE_O, // Position on
    input wire logic SPEED_MEASURE_O // Speed on
);
    // ********
    // Bus cycles
    // ********
    wire ctrl_go = WR_I && ADDR_I == `TCB_OFF_CTRL && WDATA_I[0];
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence en_wr_s;
        WR_I && ADDR_I == `TCB_OFF_IRQ_EN;
    endsequence
    sequence dis_wr_s;
        WR_I && ADDR_I == `TCB_OFF_IRQ_DIS && (WDATA_I & 32'h91) == 32'h91;
    endsequence
    sequence mask_rd_s;
        RD_I && ADDR_I == `TCB_OFF_IRQ_MASK;
    endsequence
    sequence mode_rd_s;
        RD_I && ADDR_I == `TCB_OFF_MODE;
    endsequence
    // ********
    // Checks
    // ********
    sync_pulse_a: assert property ((ctrl_go ##1 !ctrl_go) |-> SYNC_O ##1 !SYNC_O)
        else $error("trigger pulse missing or too long");
    sync_cause_a: assert property (SYNC_O |-> $past(ctrl_go))
        else $error("trigger pulse without a control write");
    rd_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
        else $error("read data outside the answer cycle");
    mask_set_a: assert property (en_wr_s ##2 mask_rd_s |=>
        (RDATA_O[7:0] & $past(WDATA_I[7:0], 3)) == $past(WDATA_I[7:0], 3))
        else $error("enabled mask bit not set");
    mask_clr_a: assert property (dis_wr_s ##2 mask_rd_s |=> (RDATA_O & 32'h91) == 32'h0)
        else $error("disabled mask bit still set");
    mode_resv_a: assert property (mode_rd_s |=> (RDATA_O & ~`TCB_MODE_MASK) == 32'h0)
        else $error("reserved mode bits read non-zero");
    clk0_pin_a: assert property (mode_rd_s ##1 (RDATA_O[1:0] == 2'h0) |->
        EXT_CLOCK_LINE0_O == $past(CLK_PIN0_I))
        else $error("clock line 0 not from its pin");
    clk0_chan_a: assert property (mode_rd_s ##1 (RDATA_O[1:0] == 2'h2) |->
        EXT_CLOCK_LINE0_O == $past(CHAN1_IO_A_I))
        else $error("clock line 0 not from channel 1 A");
    meas_sel_a: assert property (mode_rd_s |=> POS_MEASURE_O == (RDATA_O[8] & RDATA_O[9])
        && SPEED_MEASURE_O == (RDATA_O[8] & RDATA_O[10]))
        else $error("measure outputs disagree with mode");
endmodule
bind tcb_block tcb_chk tcb_chk_i (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .CLK_PIN0_I(CLK_PIN0_I),
    .CHAN1_IO_A_I(CHAN1_IO_A_I), .SYNC_O(SYNC_O), .EXT_CLOCK_LINE0_O(EXT_CLOCK_LINE0_O),
    .POS_MEASURE_O(POS_MEASURE_O), .SPEED_MEASURE_O(SPEED_MEASURE_O));
`default_nettype wire

// File: test/tcb_block_tb.sv
// Purpose: Self-checking bench of the timer block controls
// Assumes: Encoder model drives channel 0 pins A and B
// Notes: Read words are checked against a queue of notes
`include "tcb_regs.vh"
`default_nettype none
module tcb_block_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] EN = `TCB_OFF_IRQ_EN;
    localparam logic [31:0] DIS = `TCB_OFF_IRQ_DIS;
    localparam logic [31:0] MSK = `TCB_OFF_IRQ_MASK;
    localparam logic [31:0] MD = `TCB_OFF_MODE;
    localparam logic [31:0] WP = `TCB_OFF_WPROT;
    logic CLK_I = 1'b0;
    logic RST_N_I = 1'b0;
    logic [31:0] ADDR_I = 32'h0;
    logic [31:0] WDATA_I = 32'h0;
    logic WR_I = 1'b0;
    logic RD_I = 1'b0;
    logic [7:0] EVENT_I = 8'h0;
    logic WAVE_MODE_I = 1'b0;
    logic [4:0] pin = 5'h0;
    logic run = 1'b0;
    logic rd_q = 1'b0;
    logic sx = 1'b0;
    logic a, b, sync, irq, edg, pos, spd, dir, dchg;
    int dcs = 0;
    logic [2:0] xc, ph;
    logic [31:0] rdata, r, e;
    logic [31:0] exp_q[$];
    int error_cnt = 0;
    int compares = 0;
    int edges = 0;
    int i, n;
    tcb_enc tcb_enc_i (.clk_i(CLK_I), .run_i(run), .per_i(4'h7), .a_o(a), .b_o(b));
    tcb_block tcb_block_i (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I),
        .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(rdata), .EVENT_I(EVENT_I),
        .WAVE_MODE_I(WAVE_MODE_I), .CLK_PIN0_I(pin[0]), .CLK_PIN1_I(pin[1]),
        .CLK_PIN2_I(pin[2]), .CHAN0_IO_A_I(a), .CHAN1_IO_A_I(pin[3]), .CHAN2_IO_A_I(pin[4]),
        .CHAN0_IO_B_I(b), .IRQ_O(irq), .SYNC_O(sync), .EXT_CLOCK_LINE0_O(xc[0]),
        .EXT_CLOCK_LINE1_O(xc[1]), .EXT_CLOCK_LINE2_O(xc[2]), .PHASE_A_O(ph[0]),
        .PHASE_B_O(ph[1]), .INDEX_O(ph[2]), .EDGE_O(edg), .DIR_O(dir), .DIR_CHANGE_O(dchg),
        .POS_MEASURE_O(pos), .SPEED_MEASURE_O(spd));
    // ********
    // Clock, monitor and helpers
    // ********
    initial forever #20 CLK_I = ~CLK_I;
    // Note strobes, trigger writes and edge pulses
    always @(posedge CLK_I)
    begin
        rd_q <= RD_I;
        sx <= WR_I && ADDR_I == `TCB_OFF_CTRL && WDATA_I[0];
        edges <= edges + int'(edg);
        dcs <= dcs + int'(dchg);
    end
    // Compare read words with the oldest note, trigger every cycle out of reset
    always @(negedge CLK_I)
    begin
        if (rd_q)
            chk("rdata", exp_q.pop_front(), rdata);
        if (RST_N_I)
            chk("sync", 32'(sx), 32'(sync));
    end
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
        compares++;
        if (s !== ex)
        begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", nm, ex, s);
        end
    endtask
    // One write or read cycle, then one idle cycle
    task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] d);
        if (!w)
            exp_q.push_back(d);
        ADDR_I <= ad;
        WDATA_I <= d;
        WR_I <= w;
        RD_I <= !w;
        @(posedge CLK_I);
        WR_I <= 1'b0;
        RD_I <= 1'b0;
        @(posedge CLK_I);
    endtask
    task automatic final_report();
        $display("counts: %0d compares, %0d errors", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Cut a hung run short
    initial
    begin
        repeat (20000) @(posedge CLK_I);
        error_cnt++;
        final_report();
    end
    // ********
    // Tests
    // ********
    initial
    begin
        r = $urandom(32'hc5d8);
        repeat (8) @(posedge CLK_I);
        RST_N_I <= 1'b1;
        @(posedge CLK_I);
        bus(0, MSK, 32'h0);
        bus(0, MD, 32'h0);
        bus(0, 32'h4008_0030, 32'h0);
        r = $urandom;
        bus(1, EN, 32'h0);
        bus(1, EN, r);
        bus(0, MSK, {24'h0, r[7:0]});
        for (i = 0; i < 2; i++)
        begin
            WAVE_MODE_I <= i[0];
            bus(1, EN, 32'hFF);
            bus(1, DIS, 32'hFFFF_FFFF);
            bus(0, MSK, i ? 32'h62 : 32'h0C);
        end
        bus(1, `TCB_OFF_CTRL, 32'hFFFF_FFFE);
        bus(1, `TCB_OFF_CTRL, 32'h1);
        $display("test masks and trigger done");
        for (i = 0; i < 4; i++)
        begin
            pin <= 5'($urandom);
            bus(1, MD, 32'(i * 21));
            bus(0, MD, 32'(i * 21));
            e = i < 2 ? pin[2:0] : i == 2 ? {a, a, pin[3]} : {pin[3], pin[4], pin[4]};
            chk("xclk", e, 32'(xc));
        end
        r = $urandom & `TCB_MODE_MASK | 32'h100;
        if (!r[10])
            r[9] = 1'b1;
        bus(1, MD, r);
        bus(0, MD, r);
        chk("meas", {r[9], r[10]}, {pos, spd});
        $display("test mode done");
        run <= 1'b1;
        repeat (20 + $urandom % 20) @(posedge CLK_I);
        run <= 1'b0;
        for (i = 0; i < 7; i++)
        begin
            r = i ? 32'h0010_0300 | 32'h1 << (11 + i) : 32'h0;
            bus(1, MD, r);
            repeat (6) @(posedge CLK_I);
            e = {(r[17] ? b : pin[3]) ^ r[15], r[16] ? a ^ r[13] : b ^ r[14],
                r[16] ? b ^ r[14] : a ^ r[13]};
            chk("phase", r[8] ? e : 32'h0, 32'(ph));
        end
        // Pass 2 runs transparent: edges on phase A, no direction changes
        for (i = 0; i < 3; i++)
        begin
            bus(1, MD, 32'h0010_0300 | (i == 2 ? 32'h0000_0800 : 32'(i) << 12));
            #1 edges = 0;
            dcs = 0;
            run <= 1'b1;
            repeat (36) @(posedge CLK_I);
            run <= 1'b0;
            repeat (8) @(posedge CLK_I);
            chk("edges", i == 1 ? 4 : 2, edges);
            if (i == 2)
                chk("dirchg", 0, dcs);
            else
                chk("dir", 0, 32'(dir));
        end
        $display("test decoder done");
        bus(1, EN, 32'h80);
        EVENT_I <= 8'h80;
        @(posedge CLK_I);
        EVENT_I <= 8'h0;
        for (n = 0; n < 8 && irq !== 1'b1; n++) @(posedge CLK_I);
        chk("irq", 1, irq);
        if (n == 8)
            final_report();
        bus(1, DIS, 32'h80);
        #1 chk("irq", 0, irq);
        bus(1, EN, 32'h80);
        #1 chk("irq", 1, irq);
        bus(0, `TCB_OFF_STATUS, 32'h80);
        repeat (2) @(posedge CLK_I);
        #1 chk("irq", 0, irq);
        $display("test interrupt done");
        bus(1, MD, 32'h1);
        bus(1, WP, {`TCB_WP_KEY, 8'h01});
        bus(1, MD, 32'h2);
        bus(0, MD, 32'h1);
        bus(1, WP, 32'h1234_5600);
        bus(1, MD, 32'h2);
        bus(0, MD, 32'h1);
        bus(1, WP, {`TCB_WP_KEY, 8'h00});
        bus(1, MD, 32'h2);
        bus(0, MD, 32'h2);
        $display("test protection done");
        repeat (4) @(posedge CLK_I);
        final_report();
    end
endmodule
`default_nettype wire

// File: test/tcb_enc.sv
// Purpose: Rotary encoder model on channel 0 pins A and B
// Assumes: One quadrature step every per_i+1 cycles while turning
// Notes: Holds its last position while stopped
`default_nettype none
module tcb_enc (
    input wire logic clk_i, // Clock
    input wire logic run_i, // Shaft turning
    input wire logic [3:0] per_i, // Step period less one
    output logic a_o, // Phase A
    output logic b_o // Phase B
);
    logic [3:0] cnt_q = 4'h0;
    logic [1:0] pos_q = 2'h0;
    // ********
    // Step counter
    // ********
    always @(posedge clk_i)
    begin
        cnt_q <= (run_i && cnt_q != per_i) ? cnt_q + 4'h1 : 4'h0;
        if (run_i && cnt_q == per_i)
            pos_q <= pos_q + 2'h1;
    end
    // Gray code phases
    assign a_o = pos_q[1];
    assign b_o = pos_q[1] ^ pos_q[0];
endmodule
`default_nettype wire
